// ===== rtl/vmc_top.sv
// How it works
// - in virtual_8086_mode linear base is segment times 16 plus offset
// - each task's flags image decides virtual_8086_mode or protected addressing
// - with paging on, the 1 MB space is relocated anywhere in 4 GB
// - virtual_8086_mode always runs at current_privilege_level 3 with checks
// - privileged instruction in virtual_8086_mode raises general protection fault
// - sensitive set: clear/set int flag, int n, interrupt_return_instr, pop and push flags
// - breakpoint, overflow and bound interrupts skip the io privilege check
// - interrupt in virtual_8086_mode goes to protected mode at privilege 0
// - virtual_mode_flag bit 17 cleared; pushed image keeps it set
// - interrupt_return_instr restores flags with the flag set and resumes
// - interrupt_return_instr at privilege 0 with image flag 1 enters virtual_8086_mode
// - task switch with image flag 1 enters virtual_8086_mode
// - pop_flags_instr never changes virtual_mode_flag
// - only interrupts or exceptions leave virtual_8086_mode
// - exit needs 32-bit int/trap gate, non-conforming, privilege 0, or 32-bit task
// - sensitive operation allowed only if privilege <= io_privilege_level
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module vmc_top #(
	parameter int WB_AW = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// classic wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [WB_AW-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// instruction and interrupt events from the core
	input wire vmc_pkg::vmc_evt_t i_evt,
	output vmc_pkg::vmc_resp_t o_resp,
	// address formation
	input wire vmc_pkg::vmc_areq_t i_areq,
	output vmc_pkg::vmc_aresp_t o_aresp,
	// state and interrupt
	output vmc_pkg::vmc_mode_t o_mode,
	output logic o_irq
);
	import vmc_pkg::*;

	// ==========================================================
	// elaboration check
	if (WB_AW < 5) begin : g_bad_aw
		$error("vmc_top: WB_AW must be at least 5");
	end

	// ==========================================================
	// state
	vmc_mode_t mode_q, mode_d;
	logic [1:0] cpl_q, cpl_d;
	logic [31:0] flags_q, flags_d;
	logic [1:0] ctrl_q;
	logic [19:0] reloc_q;
	logic [IRQ_N-1:0] irq_stat_q, irq_mask_q, irq_set;
	logic gp_d, enter_d, exit_d, gate_err_d, done_d;
	logic [31:0] img_d;

	// ==========================================================
	// wishbone decode
	logic wb_req, wb_wr;
	logic [7:0] wb_off;
	assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign wb_wr = wb_req && i_wb_we;
	assign wb_off = {{(8 - 5){1'b0}}, i_wb_adr[4:0]} & 8'hfc;

	// ==========================================================
	// event decision
	logic [1:0] io_privilege_level;
	logic io_ok, gate_ok, is_v86, is_sens;
	assign io_privilege_level = flags_q[FLG_IO_PRIVILEGE_LEVEL_LO +: 2];
	assign io_ok = (cpl_q <= io_privilege_level);
	assign is_v86 = (mode_q == MODE_V86);
	// exit only through a 32-bit gate to a level 0 non-conforming segment or a 32-bit task
	assign gate_ok = i_evt.gate32 && ((i_evt.gate == GATE_TASK) ||
		(((i_evt.gate == GATE_INT) || (i_evt.gate == GATE_TRAP)) &&
		!i_evt.gate_conf && (i_evt.gate_dpl == PL_KERNEL)));

	// sensitive set differs by mode; breakpoint, overflow, bound and exception events never checked
	always_comb begin
		unique case (i_evt.kind)
			EV_CLI, EV_STI: is_sens = 1'b1;
			EV_INTN, EV_INTERRUPT_RETURN_INSTR, EV_POP_FLAGS_INSTR, EV_PUSH_FLAGS_INSTR: is_sens = is_v86;
			default: is_sens = 1'b0;
		endcase
	end

	// next architectural state for one event
	always_comb begin
		mode_d = mode_q;
		cpl_d = cpl_q;
		flags_d = flags_q;
		gp_d = 1'b0;
		enter_d = 1'b0;
		exit_d = 1'b0;
		gate_err_d = 1'b0;
		done_d = 1'b0;
		img_d = flags_q;
		if (i_evt.valid) begin
			done_d = 1'b1;
			if (is_sens && !io_ok) begin
				gp_d = 1'b1;
			end else begin
				unique case (i_evt.kind)
					EV_CLI: flags_d[FLG_IF] = 1'b0;
					EV_STI: flags_d[FLG_IF] = 1'b1;
					EV_PUSH_FLAGS_INSTR: img_d = flags_q;
					EV_PRIV: begin
						// privilege 3 tasks never run these
						gp_d = is_v86 || (cpl_q != PL_KERNEL);
					end
					EV_POP_FLAGS_INSTR: begin
						flags_d = i_evt.image | FLAGS_RST;
						flags_d[FLG_VM] = flags_q[FLG_VM];
						if (cpl_q != PL_KERNEL) begin
							flags_d[FLG_IO_PRIVILEGE_LEVEL_LO +: 2] = io_privilege_level;
						end
					end
					EV_INTERRUPT_RETURN_INSTR: begin
						flags_d = i_evt.image | FLAGS_RST;
						if (is_v86) begin
							flags_d[FLG_VM] = 1'b1;
							flags_d[FLG_IO_PRIVILEGE_LEVEL_LO +: 2] = io_privilege_level;
						end else if (mode_q == MODE_PROT && cpl_q == PL_KERNEL &&
							i_evt.image[FLG_VM]) begin
							mode_d = MODE_V86;
							cpl_d = PL_USER;
							enter_d = 1'b1;
						end else begin
							flags_d[FLG_VM] = 1'b0;
						end
					end
					EV_TASKSW: begin
						if (is_v86 || mode_q == MODE_REAL) begin
							gp_d = 1'b1;
						end else begin
							flags_d = i_evt.image | FLAGS_RST;
							if (i_evt.image[FLG_VM]) begin
								mode_d = MODE_V86;
								cpl_d = PL_USER;
								enter_d = 1'b1;
							end
						end
					end
					EV_INTN, EV_BRK, EV_INTO, EV_BOUND, EV_EXC: begin
						if (is_v86) begin
							if (gate_ok) begin
								img_d = flags_q;
								flags_d[FLG_VM] = 1'b0;
								if (i_evt.gate == GATE_INT) begin
									flags_d[FLG_IF] = 1'b0;
								end
								mode_d = MODE_PROT;
								cpl_d = PL_KERNEL;
								exit_d = 1'b1;
							end else begin
								gp_d = 1'b1;
								gate_err_d = 1'b1;
							end
						end else begin
							img_d = flags_q;
							if (mode_q == MODE_REAL || i_evt.gate == GATE_INT) begin
								flags_d[FLG_IF] = 1'b0;
							end
							if (mode_q == MODE_PROT && i_evt.gate != GATE_TASK) begin
								cpl_d = i_evt.gate_dpl;
							end
						end
					end
					default: gp_d = 1'b1; // unknown event code is refused
				endcase
			end
		end
	end

	// ==========================================================
	// mode, privilege and flags; a control write may switch real/protected,
	// but is ignored in virtual_8086_mode since only interrupts may leave it
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_q <= MODE_REAL;
			cpl_q <= PL_KERNEL;
			flags_q <= FLAGS_RST;
		end else if (i_evt.valid) begin
			mode_q <= mode_d;
			cpl_q <= cpl_d;
			flags_q <= flags_d;
		end else if (wb_wr && wb_off == REG_CTRL && i_wb_sel[0] && !is_v86) begin
			mode_q <= i_wb_dat[CTRL_PE] ? MODE_PROT : MODE_REAL;
			if (!i_wb_dat[CTRL_PE]) begin
				cpl_q <= PL_KERNEL;
			end
		end
	end

	// event response, one cycle after the event
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_resp <= '0;
		end else begin
			o_resp.done <= done_d;
			o_resp.gp <= gp_d;
			o_resp.image <= img_d;
		end
	end

	// ==========================================================
	// address formation; real and virtual_8086_mode share the shifted-segment path
	logic [20:0] seg_lin;
	logic [31:0] lin_d;
	logic lim_bad;
	assign seg_lin = ({5'h00, i_areq.seg} << SEG_SHIFT) + {5'h00, i_areq.off[15:0]};
	// offsets past the 64K segment limit fault outside protected mode
	assign lim_bad = (i_areq.off > {16'h0000, SEG_LIMIT}) && (mode_q != MODE_PROT);
	always_comb begin
		lin_d = {11'h000, seg_lin};
		if (mode_q == MODE_PROT) begin
			lin_d = i_areq.base + i_areq.off;
		end else if (is_v86 && ctrl_q[CTRL_PG]) begin
			// relocation on 4 KB frames; without paging the task sits at 0
			lin_d = {reloc_q, 12'h000} + {11'h000, seg_lin};
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_aresp <= '0;
		end else begin
			o_aresp.valid <= i_areq.valid;
			o_aresp.fault <= i_areq.valid && lim_bad;
			o_aresp.lin <= lin_d;
		end
	end

	// ==========================================================
	// control and relocation registers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_q <= CTRL_RST;
			reloc_q <= RELOC_RST;
		end else if (wb_wr) begin
			if (wb_off == REG_CTRL && i_wb_sel[0]) begin
				ctrl_q[CTRL_PG] <= i_wb_dat[CTRL_PG];
			end
			if (wb_off == REG_RELOC) begin
				if (i_wb_sel[1]) reloc_q[3:0] <= i_wb_dat[15:12];
				if (i_wb_sel[2]) reloc_q[11:4] <= i_wb_dat[23:16];
				if (i_wb_sel[3]) reloc_q[19:12] <= i_wb_dat[31:24];
			end
		end
	end

	// ==========================================================
	// sticky event bits: a new event wins over a write-one clear
	assign irq_set = {gate_err_d, exit_d, enter_d, gp_d};
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_stat_q <= '0;
			irq_mask_q <= IRQ_MASK_RST;
		end else begin
			if (wb_wr && wb_off == REG_IRQ_STAT && i_wb_sel[0]) begin
				irq_stat_q <= (irq_stat_q & ~i_wb_dat[IRQ_N-1:0]) | irq_set;
			end else begin
				irq_stat_q <= irq_stat_q | irq_set;
			end
			if (wb_wr && wb_off == REG_IRQ_MASK && i_wb_sel[0]) begin
				irq_mask_q <= i_wb_dat[IRQ_N-1:0];
			end
		end
	end
	assign o_irq = |(irq_stat_q & irq_mask_q);
	assign o_mode = mode_q;

	// ==========================================================
	// read mux and ack; unmapped offsets read zero and still ack
	logic [31:0] rd_d;
	always_comb begin
		rd_d = 32'h0000_0000;
		unique case (wb_off)
			REG_CTRL: rd_d = {30'h0, ctrl_q[CTRL_PG], mode_q != MODE_REAL};
			REG_STATUS: rd_d = {28'h0, cpl_q, mode_q};
			REG_FLAGS: rd_d = flags_q;
			REG_RELOC: rd_d = {reloc_q, 12'h000};
			REG_IRQ_STAT: rd_d = {28'h0, irq_stat_q};
			REG_IRQ_MASK: rd_d = {28'h0, irq_mask_q};
			default: rd_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else begin
			o_wb_ack <= wb_req;
			o_wb_dat <= wb_req ? rd_d : 32'h0000_0000;
		end
	end
endmodule : vmc_top

// ===== rtl/vmc_pkg.sv
package vmc_pkg;
	// ==========================================================
	// register offsets (byte addresses, one word each)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_FLAGS = 8'h08;
	localparam logic [7:0] REG_RELOC = 8'h0c;
	localparam logic [7:0] REG_IRQ_STAT = 8'h10;
	localparam logic [7:0] REG_IRQ_MASK = 8'h14;
	// ==========================================================
	// field positions
	localparam int CTRL_PE = 0;
	localparam int CTRL_PG = 1;
	localparam int FLG_IF = 9;
	localparam int FLG_IO_PRIVILEGE_LEVEL_LO = 12;
	localparam int FLG_VM = 17;
	localparam int RELOC_LO = 12;
	localparam int IRQ_GP = 0;
	localparam int IRQ_ENTER = 1;
	localparam int IRQ_EXIT = 2;
	localparam int IRQ_GATE = 3;
	localparam int IRQ_N = 4;
	// ==========================================================
	// reset values and constants
	localparam logic [31:0] FLAGS_RST = 32'h0000_0002;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [19:0] RELOC_RST = 20'h00000;
	localparam logic [IRQ_N-1:0] IRQ_MASK_RST = 4'h0;
	localparam logic [1:0] PL_KERNEL = 2'h0;
	localparam logic [1:0] PL_USER = 2'h3;
	localparam int SEG_SHIFT = 4; // segment times 16
	localparam logic [15:0] SEG_LIMIT = 16'hffff;
	// ==========================================================
	// modes, events, gates
	typedef enum logic [1:0] {
		MODE_REAL = 2'b00,
		MODE_PROT = 2'b01,
		MODE_V86 = 2'b10
	} vmc_mode_t;
	typedef enum logic [3:0] {
		EV_CLI = 4'h0, // clear_int_flag_instr
		EV_STI = 4'h1, // set_int_flag_instr
		EV_INTN = 4'h2, // software interrupt with operand
		EV_BRK = 4'h3, // breakpoint_instr
		EV_INTO = 4'h4,
		EV_BOUND = 4'h5,
		EV_INTERRUPT_RETURN_INSTR = 4'h6, // interrupt_return_instr
		EV_POP_FLAGS_INSTR = 4'h7, // pop_flags_instr
		EV_PUSH_FLAGS_INSTR = 4'h8, // push_flags_instr
		EV_PRIV = 4'h9, // any privileged instruction
		EV_EXC = 4'ha, // external interrupt or exception
		EV_TASKSW = 4'hb // task switch, image from task_state_segment
	} vmc_kind_t;
	typedef enum logic [1:0] {
		GATE_INT = 2'b00,
		GATE_TRAP = 2'b01,
		GATE_TASK = 2'b10,
		GATE_OTHER = 2'b11
	} vmc_gate_t;
	typedef struct packed {
		logic valid;
		vmc_kind_t kind;
		logic [31:0] image; // stacked / task / popped flags image
		vmc_gate_t gate;
		logic gate32;
		logic gate_conf;
		logic [1:0] gate_dpl;
	} vmc_evt_t;
	typedef struct packed {
		logic done;
		logic gp;
		logic [31:0] image; // flags image to push
	} vmc_resp_t;
	typedef struct packed {
		logic valid;
		logic [15:0] seg;
		logic [31:0] off;
		logic [31:0] base; // descriptor base for protected mode
	} vmc_areq_t;
	typedef struct packed {
		logic valid;
		logic fault;
		logic [31:0] lin;
	} vmc_aresp_t;
endpackage : vmc_pkg

// ===== test/vmc_props.sv
`timescale 1ns/1ps
module vmc_props import vmc_pkg::*; #(
	parameter int WB_AW = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// register bus
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [WB_AW-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	// core side
	input wire vmc_evt_t i_evt,
	input wire vmc_resp_t o_resp,
	input wire vmc_areq_t i_areq,
	input wire vmc_aresp_t o_aresp,
	input wire vmc_mode_t o_mode,
	input wire logic o_irq
);
	// ========
	// helpers: an exit counts only through a gate that can return
	logic ev, virt, irq_k, gok;
	assign ev = i_evt.valid;
	assign virt = o_mode == MODE_V86;
	assign irq_k = i_evt.kind inside {EV_INTN, EV_BRK, EV_INTO, EV_BOUND, EV_EXC};
	assign gok = i_evt.gate32 && (i_evt.gate == GATE_TASK
		|| (!i_evt.gate[1] && !i_evt.gate_conf && i_evt.gate_dpl == PL_KERNEL));
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ========
	// properties
	AST_ACK: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
		else $error("ack not one pulse");
	AST_DONE: assert property (ev |=> o_resp.done) else $error("no done");
	AST_EXIT: assert property (ev && virt && irq_k && i_evt.kind != EV_INTN && gok
		|=> o_mode == MODE_PROT && !o_resp.gp && o_resp.image[FLG_VM]) else $error("bad exit");
	AST_BADGATE: assert property (ev && virt && i_evt.kind == EV_EXC && !gok
		|=> o_resp.gp && virt) else $error("bad gate taken");
	AST_STAY: assert property (virt && !(ev && irq_k) |=> virt) else $error("left mode");
	AST_PRIV: assert property (ev && virt && i_evt.kind == EV_PRIV |=> o_resp.gp && virt)
		else $error("privileged not faulted");
	AST_POP_FLAGS_INSTR: assert property (ev && i_evt.kind == EV_POP_FLAGS_INSTR |=> o_mode == $past(o_mode))
		else $error("pop flags changed mode");
	AST_TASK: assert property (ev && i_evt.kind == EV_TASKSW && o_mode == MODE_PROT
		&& i_evt.image[FLG_VM] |=> virt) else $error("task switch no entry");
	AST_LIN: assert property (i_areq.valid && o_mode == MODE_REAL |=> o_aresp.valid
		&& o_aresp.lin == {12'h0, $past(i_areq.seg), 4'h0} + {16'h0, $past(i_areq.off[15:0])})
		else $error("linear address wrong");
endmodule : vmc_props
bind vmc_top vmc_props #(.WB_AW(WB_AW)) vmc_props_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
	.i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.i_evt(i_evt), .o_resp(o_resp), .i_areq(i_areq), .o_aresp(o_aresp), .o_mode(o_mode),
	.o_irq(o_irq));

// ===== test/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
	$display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tb;
	import vmc_pkg::*;
	// ========
	// stimulus and observed signals
	logic i_clk = 0, i_rst_n = 0, cyc = 0, we = 0, o_wb_ack, o_irq;
	logic [7:0] adr = 0;
	logic [31:0] wdat = 0, rd, o_wb_dat;
	vmc_evt_t evt = '0;
	vmc_resp_t resp, r;
	vmc_areq_t areq = '0;
	vmc_aresp_t aresp;
	vmc_mode_t mode;
	int fail_count = 0, total_checks = 0;
	localparam logic [5:0] GOOD = 6'h08; // 32-bit int gate, privilege 0
	vmc_kind_t kk[4] = '{EV_BRK, EV_INTO, EV_BOUND, EV_EXC};
	vmc_kind_t sens[7] = '{EV_CLI, EV_STI, EV_INTN, EV_INTERRUPT_RETURN_INSTR, EV_POP_FLAGS_INSTR, EV_PUSH_FLAGS_INSTR, EV_PRIV};
	vmc_top vmc_top_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(cyc),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
		.o_wb_ack(o_wb_ack), .i_evt(evt), .o_resp(resp), .i_areq(areq), .o_aresp(aresp),
		.o_mode(mode), .o_irq(o_irq));
	// 125 MHz
	always #4 i_clk = ~i_clk;
	// ========
	// tasks
	task automatic conclude;
		if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude
	function automatic logic gok(input logic [5:0] g);
		return g[3] && (g[5:4] == GATE_TASK || (!g[5] && !g[2] && g[1:0] == PL_KERNEL));
	endfunction : gok
	// classic cycle; idle cycle after it so the next call never overlaps
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			conclude();
		end
		rd = o_wb_dat;
		cyc <= 1'b0;
		@(posedge i_clk);
	endtask : wb
	task automatic ex(input vmc_kind_t k, input logic [31:0] im, input logic [5:0] g,
		input logic gp, input vmc_mode_t m);
		evt <= {1'b1, k, im, g};
		@(posedge i_clk);
		evt.valid <= 1'b0;
		@(posedge i_clk);
		r = resp;
		`CHK(r.done, 1'b1)
		`CHK(r.gp, gp)
		`CHK(mode, m)
	endtask : ex
	task automatic ad(input logic [15:0] s, input logic [31:0] o, input logic [31:0] e,
		input logic f);
		areq <= {1'b1, s, o, 32'h0};
		@(posedge i_clk);
		areq.valid <= 1'b0;
		@(posedge i_clk);
		`CHK(aresp.valid, 1'b1)
		`CHK(aresp.fault, f)
		if (!f) `CHK(aresp.lin, e)
	endtask : ad
	// ========
	// main sequence
	initial begin
		logic [15:0] s, o;
		logic [31:0] rl;
		logic [5:0] g;
		logic ok;
		void'($urandom(11471));
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		`CHK(mode, MODE_REAL)
		wb(0, REG_FLAGS, 0); `CHK(rd, FLAGS_RST)
		wb(0, REG_STATUS, 0); `CHK(rd, 32'h0)
		wb(0, 8'h18, 0); `CHK(rd, 32'h0)
		s = $urandom;
		o = $urandom;
		ad(s, {16'h0, o}, {12'h0, s, 4'h0} + o, 1'b0);
		rl = $urandom & 32'hffff_f000;
		wb(1, REG_RELOC, rl);
		wb(0, REG_RELOC, 0); `CHK(rd, rl)
		wb(1, REG_IRQ_MASK, 32'hf);
		wb(1, REG_CTRL, 32'h3); `CHK(mode, MODE_PROT)
		ex(EV_POP_FLAGS_INSTR, 32'h20000, GOOD, 0, MODE_PROT);
		wb(0, REG_FLAGS, 0); `CHK(rd, 32'h2)
		ex(EV_INTERRUPT_RETURN_INSTR, 32'h20002, GOOD, 0, MODE_V86);
		wb(0, REG_STATUS, 0); `CHK(rd, 32'he)
		`CHK(o_irq, 1'b1)
		ad(s, {16'h0, o}, {12'h0, s, 4'h0} + o + rl, 1'b0);
		ad(s, 32'h10000, 0, 1'b1);
		foreach (sens[i]) ex(sens[i], 32'h0, GOOD, 1, MODE_V86);
		ex(EV_EXC, 32'h0, 6'h0, 1, MODE_V86);
		// random gates: good ones exit, then return through interrupt_return_instr
		repeat (30) begin
			g = $urandom;
			ok = gok(g);
			ex(kk[$urandom % 4], 32'h0, g, !ok, ok ? MODE_PROT : MODE_V86);
			if (ok) begin
				`CHK(r.image[FLG_VM], 1'b1)
				wb(0, REG_FLAGS, 0); `CHK(rd[FLG_VM], 1'b0)
				ex(EV_INTERRUPT_RETURN_INSTR, 32'h20002, GOOD, 0, MODE_V86);
			end
		end
		ex(EV_EXC, 32'h0, GOOD, 0, MODE_PROT);
		ex(EV_INTERRUPT_RETURN_INSTR, 32'h23002, GOOD, 0, MODE_V86);
		ex(EV_INTERRUPT_RETURN_INSTR, 32'h00202, GOOD, 0, MODE_V86);
		wb(0, REG_FLAGS, 0); `CHK(rd, 32'h23202)
		ex(EV_INTN, 32'h0, GOOD, 0, MODE_PROT);
		ex(EV_TASKSW, 32'h20002, GOOD, 0, MODE_V86);
		ex(EV_TASKSW, 32'h0, GOOD, 1, MODE_V86);
		// interrupt: mask, clear, raise again
		wb(1, REG_IRQ_MASK, 0); `CHK(o_irq, 1'b0)
		wb(1, REG_IRQ_STAT, 32'hf);
		wb(1, REG_IRQ_MASK, 32'hf);
		wb(0, REG_IRQ_STAT, 0); `CHK(rd, 32'h0)
		`CHK(o_irq, 1'b0)
		ex(EV_PRIV, 32'h0, GOOD, 1, MODE_V86);
		`CHK(o_irq, 1'b1)
		conclude();
	end
endmodule : tb
